//--- src/aie_pkg.sv
// package: constants and types for the axis io environment block
// Functional notes
// - jog filter 0.05us, or ignore up to 26ms
// - direction change delays pulses 0.2ms or 0.5us in pulse modes 0-3
// - interrupt pin low on pending unless masked
// - routing bit moves start to position-change pin
// - start, position-change status and override select
// - pin 0: input, output, accel flag, one-shot
// - pin 1: input, output, decel flag, one-shot
// - pin 2: input, output, constant-speed flag low/high
// - pins 3-7: comparator match low or high
// - pin 0/1 polarity bits select flag logic
// - encoder filter 0.05us or 0.15us
// - pulser filter 0.05us or 0.15us
// - encoder decode 1x, 2x, 4x, two-pulse
// - encoder direction bit swaps count sense
// - index polarity bit, count on activation
// - pulser decode 1x, 2x, 4x, two-pulse
// - pulser direction bit swaps count sense
// - stop-event flag set at stop when enabled
// - pulse mask hides output, counting continues
// - own-axis wait term honoured only when included
// - encoder disable ignores phases, no errors
// - pulser disable ignores phases, no errors
// - sync mode 11b waits for masked axes
package aie_pkg;
  // register byte offsets and reset values
  localparam logic [7:0]  ENV2_OFS   = 8'h88;
  localparam logic [7:0]  ENV1_OFS   = 8'h8c;
  localparam logic [31:0] ENV_RESET  = 32'h0000_0000;
  // first environment register fields
  localparam int PMD_LSB  = 0;
  localparam int PCSL_BIT = 24;
  localparam int DRF_BIT  = 27;
  localparam int DIR_CHANGE_DELAY_SEL_BIT = 28;
  localparam int IRQ_PIN_MASK_BIT = 29;
  localparam int GO_ROUTING_SEL_BIT = 30;
  // second environment register fields
  localparam int P0L_BIT  = 16;
  localparam int P1L_BIT  = 17;
  localparam int ENCODER_FILTER_SEL_BIT = 18;
  localparam int PULSER_FILTER_SEL_BIT = 19;
  localparam int EIM_LSB  = 20;
  localparam int ENCODER_COUNT_DIR_BIT = 22;
  localparam int EZL_BIT  = 23;
  localparam int PIM_LSB  = 24;
  localparam int PULSER_COUNT_DIR_BIT = 26;
  localparam int STOP_EVENT_ENABLE_BIT = 27;
  localparam int COMMAND_PULSE_MASK_BIT = 28;
  localparam int SELF_WAIT_INCLUDE_BIT = 29;
  localparam int ENCODER_INPUT_DISABLE_BIT = 30;
  localparam int PULSER_INPUT_DISABLE_BIT = 31;
  // pin function and decode codes
  localparam logic [1:0] FN_IN   = 2'h0;
  localparam logic [1:0] FN_OUT  = 2'h1;
  localparam logic [1:0] FN_NEG  = 2'h2;
  localparam logic [1:0] FN_POS  = 2'h3;
  localparam logic [1:0] DEC_X1  = 2'h0;
  localparam logic [1:0] DEC_X2  = 2'h1;
  localparam logic [1:0] DEC_X4  = 2'h2;
  localparam logic [1:0] DEC_TWO = 2'h3;
  localparam logic [1:0] SYNC_WAIT = 2'h3;
  localparam logic [2:0] PMD_LAST_DIR = 3'h3;
  // filtered pin vector indices
  localparam int IX_EA = 4;
  localparam int IX_EB = 3;
  localparam int IX_EZ = 2;
  localparam int IX_PA = 1;
  localparam int IX_PB = 0;
  localparam int IX_JOG_LO = 5;
  // times in ns and derived cycle counts
  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned FAST_NS     = 50;
  localparam int unsigned SLOW_NS     = 150;
  localparam int unsigned JOG_IGN_NS  = 26_000_000;
  localparam int unsigned DLY_LONG_NS = 200_000;
  localparam int unsigned DLY_SHRT_NS = 500;
  localparam int unsigned FAST_CYC = (FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOW_CYC = (SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned JOG_CYC  = JOG_IGN_NS / CLK_NS + 1;
  localparam int unsigned LONG_CYC = (DLY_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SHRT_CYC = (DLY_SHRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 22;
  // raw field inputs, synchronised and filtered inside the block
  typedef struct packed {
    logic dr_p, dr_m, pe, ea, eb, ez, pa, pb;
  } aie_pins_t;
  // all state of the block
  typedef struct packed {
    logic [31:0]            env1, env2, rdata;
    logic [7:0]             s1, s2, filt, gs1, gs2, gpo, gpoe;
    logic [7:0][CNT_W-1:0]  cnt;
    logic [1:0]             cs1, cs2;
    logic [CNT_W-1:0]       dly;
    logic                   dir_prev, int_n, pout, pcnt, stop_flag;
    logic                   enc_up, enc_dn, enc_err, idx_evt;
    logic                   pul_up, pul_dn, pul_err;
    logic                   go_st, pcs_st, ovr, sync_ok;
  } aie_state_t;
endpackage

//--- src/aie_axis_env.sv
// module: per-axis io environment, filters, decoders and pin functions
`timescale 1ns/1ps
module aie_axis_env #(
  parameter int unsigned JOG_IGNORE_CYC = aie_pkg::JOG_CYC,
  parameter int unsigned DIR_LONG_CYC   = aie_pkg::LONG_CYC,
  parameter logic [1:0]  OWN_AXIS       = 2'h0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // field pins
  input  wire aie_pkg::aie_pins_t field_in,
  input  wire logic              common_go_input,
  input  wire logic              position_change_input_pin,
  input  wire logic [7:0]        gpio_i,
  output logic      [7:0]        gpio_o,
  output logic      [7:0]        gpio_oe,
  output logic                   int_n,
  // pulse generator side
  input  wire logic              cmd_pulse_in,
  input  wire logic              cmd_dir,
  output logic                   cmd_pulse_out,
  output logic                   cmd_count_pulse,
  // status and start control
  input  wire logic              irq_pending,
  input  wire logic              op_stop,
  input  wire logic              stop_flag_clr,
  input  wire logic              position_change_override_sel,
  output logic                   stop_event_flag,
  output logic                   go_status_bit,
  output logic                   position_change_status_bit,
  output logic                   pcs_override_en,
  input  wire logic [1:0]        sync_start_mode,
  input  wire logic [3:0]        wait_mask,
  input  wire logic [3:0]        axis_stopped,
  output logic                   sync_start_ok,
  // pin function sources
  input  wire logic              accel_phase_flag,
  input  wire logic              decel_phase_flag,
  input  wire logic              const_speed_flag,
  input  wire logic [4:0]        cmp_match,
  input  wire logic [7:0]        gpio_out_data,
  input  wire logic              oneshot_pulse,
  output logic      [7:0]        gpio_in_data,
  // decoded counts and filtered jog pins
  output logic                   enc_up,
  output logic                   enc_dn,
  output logic                   enc_err,
  output logic                   idx_event,
  output logic                   pul_up,
  output logic                   pul_dn,
  output logic                   pul_err,
  output logic      [2:0]        jog_filtered
);
  localparam int CNT_W = aie_pkg::CNT_W;  // filter and delay counter width
  aie_pkg::aie_state_t q;
  aie_pkg::aie_state_t d;
  logic                hold;
  logic                dir_chg;
  logic                pcs_act;
  logic [3:0]          wait_ok;

  ////////////////////////////////////////////////////////////////////////
  // quadrature and two-pulse decoder: returns {err, down, up}
  function automatic logic [2:0] quad_dec(input logic [1:0] p,
                                          input logic [1:0] c,
                                          input logic [1:0] mode,
                                          input logic       swap);
    logic fwd;
    logic rev;
    logic up;
    logic dn;
    logic err;
    fwd = (p == 2'h0 && c == 2'h2) || (p == 2'h2 && c == 2'h3) ||
          (p == 2'h3 && c == 2'h1) || (p == 2'h1 && c == 2'h0);
    rev = (c == 2'h0 && p == 2'h2) || (c == 2'h2 && p == 2'h3) ||
          (c == 2'h3 && p == 2'h1) || (c == 2'h1 && p == 2'h0);
    err = ((p ^ c) == 2'h3) && (mode != aie_pkg::DEC_TWO);
    unique case (mode)
      aie_pkg::DEC_X1: begin
        // a edges with b low only
        up = ~p[1] & c[1] & ~c[0];
        dn = p[1] & ~c[1] & ~c[0];
      end
      aie_pkg::DEC_X2: begin
        up = fwd & (p[1] ^ c[1]);
        dn = rev & (p[1] ^ c[1]);
      end
      aie_pkg::DEC_X4: begin
        up = fwd;
        dn = rev;
      end
      aie_pkg::DEC_TWO: begin
        // a rises count up, b rises count down
        up = ~p[1] & c[1];
        dn = ~p[0] & c[0];
      end
    endcase
    return swap ? {err, up, dn} : {err, dn, up};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // combinational helpers
  always_comb begin
    dir_chg = (cmd_dir != q.dir_prev) &&
              (q.env1[aie_pkg::PMD_LSB +: 3] <= aie_pkg::PMD_LAST_DIR);
    hold    = dir_chg || (q.dly != '0);
    // position-change pin in programmed logic
    pcs_act = ~(q.cs2[0] ^ q.env1[aie_pkg::PCSL_BIT]);
    for (int i = 0; i < 4; i++) begin
      // own axis counts only when it is included
      wait_ok[i] = ~wait_mask[i] | (axis_stopped[i] &
                   ((OWN_AXIS != 2'(i)) | q.env2[aie_pkg::SELF_WAIT_INCLUDE_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [CNT_W-1:0] thr;
    logic [2:0]       e;
    logic [2:0]       p;
    logic [1:0]       fn;
    logic             v;
    thr = '0;
    e   = '0;
    p   = '0;
    fn  = '0;
    v   = 1'b0;
    d   = q;
    // register writes and reads
    if (reg_wr && reg_addr == aie_pkg::ENV1_OFS) begin
      d.env1 = reg_wdata;
    end
    if (reg_wr && reg_addr == aie_pkg::ENV2_OFS) begin
      d.env2 = reg_wdata;
    end
    if (reg_rd) begin
      d.rdata = (reg_addr == aie_pkg::ENV1_OFS) ? q.env1 :
                (reg_addr == aie_pkg::ENV2_OFS) ? q.env2 : '0;
    end
    // two-stage synchronisers
    d.s1  = field_in;
    d.s2  = q.s1;
    d.gs1 = gpio_i;
    d.gs2 = q.gs1;
    d.cs1 = {common_go_input, position_change_input_pin};
    d.cs2 = q.cs1;
    // noise filters: accept a level once stable long enough
    for (int i = 0; i < 8; i++) begin
      if (i >= aie_pkg::IX_JOG_LO) begin
        thr = q.env1[aie_pkg::DRF_BIT] ? CNT_W'(JOG_IGNORE_CYC) :
              CNT_W'(aie_pkg::FAST_CYC);
      end else if (i >= aie_pkg::IX_EZ) begin
        thr = q.env2[aie_pkg::ENCODER_FILTER_SEL_BIT] ? CNT_W'(aie_pkg::SLOW_CYC) :
              CNT_W'(aie_pkg::FAST_CYC);
      end else begin
        thr = q.env2[aie_pkg::PULSER_FILTER_SEL_BIT] ? CNT_W'(aie_pkg::SLOW_CYC) :
              CNT_W'(aie_pkg::FAST_CYC);
      end
      if (q.s2[i] == q.filt[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] >= thr - CNT_W'(1)) begin
        d.filt[i] = q.s2[i];
        d.cnt[i]  = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + CNT_W'(1);
      end
    end
    // encoder and pulser decoding on filtered phases
    e = quad_dec({q.filt[aie_pkg::IX_EA], q.filt[aie_pkg::IX_EB]},
                 {d.filt[aie_pkg::IX_EA], d.filt[aie_pkg::IX_EB]},
                 q.env2[aie_pkg::EIM_LSB +: 2],
                 q.env2[aie_pkg::ENCODER_COUNT_DIR_BIT]);
    p = quad_dec({q.filt[aie_pkg::IX_PA], q.filt[aie_pkg::IX_PB]},
                 {d.filt[aie_pkg::IX_PA], d.filt[aie_pkg::IX_PB]},
                 q.env2[aie_pkg::PIM_LSB +: 2],
                 q.env2[aie_pkg::PULSER_COUNT_DIR_BIT]);
    if (q.env2[aie_pkg::ENCODER_INPUT_DISABLE_BIT]) begin
      e = '0;
    end
    if (q.env2[aie_pkg::PULSER_INPUT_DISABLE_BIT]) begin
      p = '0;
    end
    {d.enc_err, d.enc_dn, d.enc_up} = e;
    {d.pul_err, d.pul_dn, d.pul_up} = p;
    // index: event on inactive to active
    d.idx_evt = ~(q.filt[aie_pkg::IX_EZ] ~^ q.env2[aie_pkg::EZL_BIT]) &
                (d.filt[aie_pkg::IX_EZ] ~^ q.env2[aie_pkg::EZL_BIT]);
    // direction-change delay for step/direction formats
    d.dir_prev = cmd_dir;
    if (dir_chg) begin
      d.dly = q.env1[aie_pkg::DIR_CHANGE_DELAY_SEL_BIT] ? CNT_W'(aie_pkg::SHRT_CYC) :
              CNT_W'(DIR_LONG_CYC);
    end else if (q.dly != '0) begin
      d.dly = q.dly - CNT_W'(1);
    end
    d.pcnt = cmd_pulse_in & ~hold;
    d.pout = cmd_pulse_in & ~hold & ~q.env2[aie_pkg::COMMAND_PULSE_MASK_BIT];
    // interrupt pin
    d.int_n = ~(irq_pending & ~q.env1[aie_pkg::IRQ_PIN_MASK_BIT]);
    // stop event flag: a stop beats a clear in the same cycle
    if (op_stop && q.env2[aie_pkg::STOP_EVENT_ENABLE_BIT]) begin
      d.stop_flag = 1'b1;
    end else if (stop_flag_clr) begin
      d.stop_flag = 1'b0;
    end
    // start routing and status
    d.go_st  = q.env1[aie_pkg::GO_ROUTING_SEL_BIT] ? pcs_act : ~q.cs2[1];
    d.pcs_st = pcs_act;
    d.ovr    = position_change_override_sel & pcs_act;
    d.sync_ok = (sync_start_mode == aie_pkg::SYNC_WAIT) && (&wait_ok);
    // general pins
    for (int i = 0; i < 8; i++) begin
      fn = q.env2[2*i +: 2];
      unique case (i)
        0: v = (fn == aie_pkg::FN_NEG) ? accel_phase_flag : oneshot_pulse;
        1: v = (fn == aie_pkg::FN_NEG) ? decel_phase_flag : oneshot_pulse;
        2: v = const_speed_flag;
        default: v = cmp_match[i-3];
      endcase
      if (i < 2) begin
        v = ~(v ^ q.env2[aie_pkg::P0L_BIT + i]);
      end else begin
        v = (fn == aie_pkg::FN_POS) ? v : ~v;
      end
      d.gpo[i]  = (fn == aie_pkg::FN_OUT) ? gpio_out_data[i] : v;
      d.gpoe[i] = (fn != aie_pkg::FN_IN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.env1  <= aie_pkg::ENV_RESET;
      q.env2  <= aie_pkg::ENV_RESET;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata       = q.rdata;
  assign gpio_o          = q.gpo;
  assign gpio_oe         = q.gpoe;
  assign gpio_in_data    = q.gs2;
  assign int_n           = q.int_n;
  assign cmd_pulse_out   = q.pout;
  assign cmd_count_pulse = q.pcnt;
  assign stop_event_flag = q.stop_flag;
  assign go_status_bit   = q.go_st;
  assign position_change_status_bit = q.pcs_st;
  assign pcs_override_en = q.ovr;
  assign sync_start_ok   = q.sync_ok;
  assign enc_up          = q.enc_up;
  assign enc_dn          = q.enc_dn;
  assign enc_err         = q.enc_err;
  assign idx_event       = q.idx_evt;
  assign pul_up          = q.pul_up;
  assign pul_dn          = q.pul_dn;
  assign pul_err         = q.pul_err;
  assign jog_filtered    = q.filt[7:5];

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_int_low_pending: assert property (
    irq_pending && !q.env1[aie_pkg::IRQ_PIN_MASK_BIT] |=> !int_n)
    else $error("interrupt pin not low while pending");
  a_int_masked_high: assert property (
    q.env1[aie_pkg::IRQ_PIN_MASK_BIT] |=> int_n)
    else $error("interrupt pin low while masked");
  a_mask_hides_pulse: assert property (
    q.env2[aie_pkg::COMMAND_PULSE_MASK_BIT] && cmd_pulse_in && !hold
    |=> !cmd_pulse_out && cmd_count_pulse)
    else $error("masked pulse output or lost count");
  a_dir_short_delay: assert property (
    dir_chg && q.env1[aie_pkg::DIR_CHANGE_DELAY_SEL_BIT]
    |=> q.dly == CNT_W'(aie_pkg::SHRT_CYC))
    else $error("short direction delay not loaded");
  a_stop_flag_set: assert property (
    op_stop && q.env2[aie_pkg::STOP_EVENT_ENABLE_BIT] |=> stop_event_flag)
    else $error("stop event flag not set");
  a_stop_flag_off: assert property (
    !q.env2[aie_pkg::STOP_EVENT_ENABLE_BIT] && !stop_event_flag |=> !stop_event_flag)
    else $error("stop event flag set while disabled");
  a_enc_off_quiet: assert property (
    q.env2[aie_pkg::ENCODER_INPUT_DISABLE_BIT] |=> !enc_up && !enc_dn && !enc_err)
    else $error("encoder activity while disabled");
  a_pul_off_quiet: assert property (
    q.env2[aie_pkg::PULSER_INPUT_DISABLE_BIT] |=> !pul_up && !pul_dn && !pul_err)
    else $error("pulser activity while disabled");
  a_enc_fast_width: assert property (
    $changed(q.filt[aie_pkg::IX_EA]) && !q.env2[aie_pkg::ENCODER_FILTER_SEL_BIT] &&
    $stable(q.env2) |-> $past(q.s2[aie_pkg::IX_EA], 7) ==
    q.filt[aie_pkg::IX_EA])
    else $error("encoder level accepted too early");
  a_gpio2_pos_flag: assert property (
    q.env2[5:4] == aie_pkg::FN_POS |=> gpio_o[2] == $past(const_speed_flag))
    else $error("constant speed flag wrong on pin 2");
  a_self_wait_block: assert property (
    sync_start_mode == aie_pkg::SYNC_WAIT && !q.env2[aie_pkg::SELF_WAIT_INCLUDE_BIT] &&
    wait_mask[OWN_AXIS] |=> !sync_start_ok)
    else $error("started on own axis stop");
endmodule

//--- bench/aie_field_model.sv
// partner model: quadrature phases from an encoder or manual pulser
`timescale 1ns/1ps
module aie_field_model #(
  parameter int HOLD = 32  // reload count, a level lasts 33 cycles, above every filter
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // motion request
  input  wire logic       start,
  input  wire logic       fwd,
  input  wire logic [3:0] steps,
  // phase outputs
  output logic            a,
  output logic            b
);
  int         left;  // quarter steps still to make
  int         cnt;   // hold counter
  logic [1:0] ph;    // position within one cycle

  //////////////////////////////////////////////////////////////////////
  // step sequencer; levels held longer than the widest filter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left <= 0;
      cnt  <= 0;
      ph   <= 2'h0;
    end else if (start) begin
      left <= int'(steps);
      cnt  <= HOLD;
    end else if (left != 0) begin
      if (cnt == 0) begin
        ph   <= fwd ? ph + 2'h1 : ph - 2'h1;
        left <= left - 1;
        cnt  <= HOLD;
      end else begin
        cnt <= cnt - 1;
      end
    end
  end

  // forward: 00, 10, 11, 01, so phase a leads
  assign {a, b} = ph[1] ? {~ph[0], 1'b1} : {ph[0], 1'b0};
endmodule

//--- bench/axis_io_environment_config_test.sv
// testbench: register, pin function, status, filter and decoder checks
`timescale 1ns/1ps
module axis_io_environment_config_test;
  // bench signals
  logic        clk, resetn, reg_wr, reg_rd, cmd_pulse_in, cmd_dir;
  logic        irq_pending, op_stop, stop_flag_clr, common_go_input;
  logic        position_change_override_sel, position_change_input_pin;
  logic        accel_phase_flag, decel_phase_flag, const_speed_flag;
  logic        oneshot_pulse, dr_p, start, fwd, a, b, int_n;
  logic        cmd_pulse_out, cmd_count_pulse, stop_event_flag;
  logic        go_status_bit, position_change_status_bit, pcs_override_en;
  logic        sync_start_ok, enc_up, enc_dn, enc_err, idx_event;
  logic        pul_up, pul_dn, pul_err, ez_in;
  logic [7:0]  reg_addr, gpio_i, gpio_o, gpio_oe, gpio_in_data;
  logic [7:0]  gpio_out_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  sync_start_mode;
  logic [3:0]  wait_mask, axis_stopped, steps;
  logic [4:0]  cmp_match;
  logic [2:0]  jog_filtered;
  aie_pkg::aie_pins_t field_in;
  int          n_fail, compares;
  int          cnt [4];  // decoder pulse tallies

  // same phases feed encoder and pulser
  assign field_in = {dr_p, 1'b0, 1'b0, a, b, ez_in, a, b};

  //////////////////////////////////////////////////////////////////////
  // design and partner
  aie_axis_env #(.JOG_IGNORE_CYC(20), .DIR_LONG_CYC(30)) DUT (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .field_in, .common_go_input, .position_change_input_pin, .gpio_i,
    .gpio_o, .gpio_oe, .int_n, .cmd_pulse_in, .cmd_dir, .cmd_pulse_out,
    .cmd_count_pulse, .irq_pending, .op_stop, .stop_flag_clr,
    .position_change_override_sel, .stop_event_flag, .go_status_bit,
    .position_change_status_bit, .pcs_override_en, .sync_start_mode,
    .wait_mask, .axis_stopped, .sync_start_ok, .accel_phase_flag,
    .decel_phase_flag, .const_speed_flag, .cmp_match, .gpio_out_data,
    .oneshot_pulse, .gpio_in_data, .enc_up, .enc_dn, .enc_err,
    .idx_event, .pul_up, .pul_dn, .pul_err, .jog_filtered);
  aie_field_model model (.clk, .resetn, .start, .fwd, .steps, .a, .b);

  // clock and decoder pulse tallies
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + int'(enc_up === 1'b1);
    cnt[1] <= cnt[1] + int'(enc_dn === 1'b1);
    cnt[2] <= cnt[2] + int'(pul_up === 1'b1);
    cnt[3] <= cnt[3] + int'(pul_dn === 1'b1);
  end

  //////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr  = ad;
    reg_wdata = d;
    reg_wr    = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    reg_addr = ad;
    reg_rd   = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp, "register read");
  endtask
  task automatic pulse(input logic eo, ec);
    cmd_pulse_in = 1'b1;
    tick(1);
    cmd_pulse_in = 1'b0;
    chk(cmd_pulse_out, eo, "pulse out");
    chk(cmd_count_pulse, ec, "count pulse");
  endtask
  task automatic dly_try(input logic dir_change_delay_sel, input int gap, input logic e);
    wr(8'h8c, {3'h0, dir_change_delay_sel, 28'h000_0000});
    cmd_dir = ~cmd_dir;
    tick(gap);
    pulse(e, e);
  endtask
  task automatic jog_try(input logic jog_dir_filter_sel, input logic e);
    logic seen;
    wr(8'h8c, {4'h0, jog_dir_filter_sel, 27'h000_0000});
    seen  = 1'b0;
    dr_p  = 1'b1;
    tick(10);
    dr_p = 1'b0;
    repeat (40) begin
      tick(1);
      seen = seen | jog_filtered[2];
    end
    chk(seen, e, "jog filter");
  endtask
  task automatic run(input logic [31:0] e2, input logic f,
                     input int eu, ed, pu, pd);
    int s [4];
    wr(8'h88, e2);
    s     = cnt;
    fwd   = f;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(4 * 33 + 40);
    chk(cnt[0] - s[0], eu, "encoder up");
    chk(cnt[1] - s[1], ed, "encoder down");
    chk(cnt[2] - s[2], pu, "pulser up");
    chk(cnt[3] - s[3], pd, "pulser down");
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    rd(8'h88, 32'h0000_0000);
    rd(8'h8c, 32'h0000_0000);
    wr(8'h88, 32'ha5a5_5a5a);
    wr(8'h90, 32'hffff_ffff);
    rd(8'h88, 32'ha5a5_5a5a);
    rd(8'h90, 32'h0000_0000);
    wr(8'h8c, 32'h1234_5678);
    rd(8'h8c, 32'h1234_5678);
  endtask
  task automatic t_gpio;
    accel_phase_flag = 1'b1;
    decel_phase_flag = 1'b1;
    const_speed_flag = 1'b1;
    cmp_match        = 5'h01;
    gpio_out_data    = 8'h10;
    oneshot_pulse    = 1'b1;
    wr(8'h88, 32'h0001_01ba);
    tick(2);
    chk(gpio_o[4:0], 5'h15, "pin levels");
    chk(gpio_oe, 8'h1f, "pin enables");
    chk(gpio_in_data, 8'h5a, "pin inputs");
    wr(8'h88, 32'h0002_002f);
    tick(2);
    chk(gpio_o[2:0], 3'h2, "one-shot polarity");
  endtask
  task automatic t_irq;
    irq_pending = 1'b1;
    wr(8'h8c, 32'h0000_0000);
    tick(1);
    chk(int_n, 1'b0, "interrupt low");
    wr(8'h8c, 32'h2000_0000);
    tick(1);
    chk(int_n, 1'b1, "interrupt masked");
    irq_pending = 1'b0;
  endtask
  task automatic t_stop;
    wr(8'h88, 32'h0000_0000);
    op_stop = 1'b1;
    tick(1);
    op_stop = 1'b0;
    tick(1);
    chk(stop_event_flag, 1'b0, "stop flag off");
    wr(8'h88, 32'h0800_0000);
    op_stop = 1'b1;
    tick(1);
    op_stop = 1'b0;
    tick(1);
    chk(stop_event_flag, 1'b1, "stop flag set");
    stop_flag_clr = 1'b1;
    tick(1);
    stop_flag_clr = 1'b0;
    tick(1);
    chk(stop_event_flag, 1'b0, "stop flag cleared");
  endtask
  task automatic t_mask;
    wr(8'h88, 32'h1000_0000);
    pulse(1'b0, 1'b1);
    wr(8'h88, 32'h0000_0000);
    pulse(1'b1, 1'b1);
  endtask
  task automatic t_dirdly;
    dly_try(1'b1, 20, 1'b0);
    dly_try(1'b1, 90, 1'b1);
    dly_try(1'b0, 10, 1'b0);
    dly_try(1'b0, 50, 1'b1);
  endtask
  task automatic t_status;
    common_go_input = 1'b0;
    wr(8'h8c, 32'h0000_0000);
    tick(4);
    chk(go_status_bit, 1'b1, "common start");
    wr(8'h8c, 32'h4000_0000);
    tick(2);
    chk(go_status_bit, 1'b0, "common start ignored");
    position_change_input_pin    = 1'b0;
    position_change_override_sel = 1'b1;
    tick(5);
    chk(go_status_bit, 1'b1, "axis start");
    chk(position_change_status_bit, 1'b1, "pcs status");
    chk(pcs_override_en, 1'b1, "override on");
    position_change_override_sel = 1'b0;
    tick(2);
    chk(pcs_override_en, 1'b0, "override off");
    common_go_input           = 1'b1;
    position_change_input_pin = 1'b1;
  endtask
  task automatic t_sync;
    sync_start_mode = 2'h3;
    wait_mask       = 4'h3;
    axis_stopped    = 4'h3;
    wr(8'h88, 32'h0000_0000);
    tick(2);
    chk(sync_start_ok, 1'b0, "own axis excluded");
    wr(8'h88, 32'h2000_0000);
    tick(2);
    chk(sync_start_ok, 1'b1, "own axis included");
    axis_stopped = 4'h1;
    tick(2);
    chk(sync_start_ok, 1'b0, "axis still moving");
    sync_start_mode = 2'h0;
  endtask
  task automatic t_jog;
    jog_try(1'b1, 1'b0);
    jog_try(1'b0, 1'b1);
  endtask
  // index in positive logic: one event on activation, none on release
  task automatic t_index;
    int n;
    n = 0;
    wr(8'h88, 32'h0080_0000);
    ez_in = 1'b1;
    repeat (20) begin
      tick(1);
      n = n + int'(idx_event === 1'b1);
    end
    ez_in = 1'b0;
    repeat (20) begin
      tick(1);
      n = n + int'(idx_event === 1'b1);
    end
    chk(n, 1, "index event");
  endtask
  task automatic t_decode;
    run(32'h0120_0000, 1'b1, 4, 0, 2, 0);
    run(32'h0300_0000, 1'b1, 1, 0, 1, 1);
    run(32'h8060_0000, 1'b1, 0, 4, 0, 0);
    run(32'h4600_0000, 1'b0, 0, 0, 4, 0);
  endtask

  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_of_test;
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test;
  end

  // main sequence
  initial begin
    {clk, resetn, reg_wr, reg_rd, cmd_pulse_in, cmd_dir} = '0;
    {irq_pending, op_stop, stop_flag_clr, dr_p, start, fwd, ez_in} = '0;
    {accel_phase_flag, decel_phase_flag, const_speed_flag} = '0;
    {oneshot_pulse, position_change_override_sel} = '0;
    common_go_input           = 1'b1;
    position_change_input_pin = 1'b1;
    {reg_addr, gpio_i, gpio_out_data, cmp_match} = '0;
    {reg_wdata, sync_start_mode, wait_mask, axis_stopped} = '0;
    steps = 4'h4;
    tick(20);
    resetn = 1'b1;
    gpio_i = 8'h5a;
    t_regs;
    t_gpio;
    t_irq;
    t_stop;
    t_mask;
    t_dirdly;
    t_status;
    t_sync;
    t_jog;
    t_index;
    t_decode;
    end_of_test;
  end
endmodule
